// ===== src/ict_pkg.sv
// instruction cycle timing: shared constants, types and timing lookup
// assumes one 50 MHz core clock; all counts are in core clocks
package ict_pkg;

    // ------------------------------------------------------------
    // clock and bus timing
    // ------------------------------------------------------------
    localparam int unsigned ICT_CLK_MHZ = 50;
    localparam int unsigned ICT_BUS_CLKS = 2;
    localparam int unsigned ICT_IACK_CLKS = 3;
    localparam logic [7:0] ICT_SAVE_CLKS = 8'h03;
    localparam logic [4:0] ICT_SAVE_FETCH = 5'h01;
    localparam logic [7:0] ICT_LONG_EXTRA = 8'h02;
    localparam logic [7:0] ICT_IMM_EXTRA = 8'h02;
    localparam logic [7:0] ICT_FAULT_MAX = 8'h3A;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ICT_BIT_IMM_DN = 5'h00, ICT_BIT_REG_DN = 5'h01,
        ICT_BIT_IMM_MEM = 5'h02, ICT_BIT_REG_MEM = 5'h03,
        ICT_TST_IMM_DN = 5'h04, ICT_TST_REG_DN = 5'h05,
        ICT_TST_IMM_MEM = 5'h06, ICT_TST_REG_MEM = 5'h07,
        ICT_DBR_TAKEN = 5'h08, ICT_DBR_LOOP = 5'h09,
        ICT_PBC = 5'h0A, ICT_FLINE1 = 5'h0B,
        ICT_FLINE2_REG = 5'h0C, ICT_FLINE2_MEM = 5'h0D,
        ICT_IRQ = 5'h0E, ICT_FAULT_INSTR = 5'h0F,
        ICT_XRET_FAULT_INSTR = 5'h10, ICT_XRET_FAULT4 = 5'h11,
        ICT_XRET_FAULT6 = 5'h12
    } ict_op_t;

    typedef enum logic [1:0] {
        ICT_READ = 2'h0, ICT_FETCH = 2'h1, ICT_WRITE = 2'h2
    } ict_kind_t;

    typedef enum logic [1:0] {
        ICT_X_NONE = 2'h0, ICT_X_READ = 2'h1, ICT_X_WRITE = 2'h2
    } ict_xk_t;

    typedef struct packed {
        logic [7:0] total;
        logic [3:0] head;
        logic signed [3:0] tail;
        logic [4:0] r;
        logic [4:0] p;
        logic [4:0] w;
        ict_xk_t xk;
        logic save;
        logic iack;
        logic imm;
        logic rerun;
    } ict_tim_t;

    typedef struct packed {
        logic [4:0] f;
        logic [4:0] r;
        logic [4:0] w;
        logic [7:0] i;
        logic iack;
    } ict_cnt_t;

    // ------------------------------------------------------------
    // per-operation timing: total(reads/fetches/writes)
    // ------------------------------------------------------------
    function automatic ict_tim_t ict_mk(logic [7:0] t, logic [3:0] h,
        logic signed [3:0] tl, logic [4:0] r, logic [4:0] p,
        logic [4:0] w, ict_xk_t xk, logic [3:0] fl);
        ict_tim_t m;
        m = '{t, h, tl, r, p, w, xk, fl[3], fl[2], fl[1], fl[0]};
        return m;
    endfunction

    function automatic ict_tim_t ict_timing(ict_op_t op);
        ict_tim_t m;
        m = ict_mk(8'h02, 4'h0, 4'sh0, 5'h00, 5'h01, 5'h00,
            ICT_X_NONE, 4'h0);
        unique case (op)
            ICT_BIT_IMM_DN: m = ict_mk(8'h06, 4'h2, 4'sh0, 5'h00, 5'h02,
                5'h00, ICT_X_NONE, 4'h2);
            ICT_BIT_REG_DN: m = ict_mk(8'h06, 4'h4, 4'sh0, 5'h00, 5'h01,
                5'h00, ICT_X_NONE, 4'h0);
            ICT_BIT_IMM_MEM: m = ict_mk(8'h08, 4'h1, 4'sh2, 5'h00, 5'h02,
                5'h01, ICT_X_WRITE, 4'h2);
            ICT_BIT_REG_MEM: m = ict_mk(8'h08, 4'h2, 4'sh2, 5'h00, 5'h01,
                5'h01, ICT_X_WRITE, 4'h0);
            ICT_TST_IMM_DN: m = ict_mk(8'h04, 4'h2, 4'sh0, 5'h00, 5'h02,
                5'h00, ICT_X_NONE, 4'h2);
            ICT_TST_REG_DN: m = ict_mk(8'h04, 4'h2, 4'sh0, 5'h00, 5'h01,
                5'h00, ICT_X_NONE, 4'h0);
            ICT_TST_IMM_MEM: m = ict_mk(8'h04, 4'h1, 4'sh0, 5'h00, 5'h02,
                5'h00, ICT_X_NONE, 4'h2);
            ICT_TST_REG_MEM: m = ict_mk(8'h08, 4'h2, 4'sh0, 5'h00, 5'h01,
                5'h00, ICT_X_NONE, 4'h0);
            ICT_DBR_TAKEN: m = ict_mk(8'h0A, 4'h6, -4'sh2, 5'h00, 5'h02,
                5'h00, ICT_X_NONE, 4'h0);
            ICT_DBR_LOOP: m = ict_mk(8'h0A, 4'h6, 4'sh0, 5'h00, 5'h00,
                5'h00, ICT_X_NONE, 4'h0);
            ICT_PBC: m = ict_mk(8'h12, 4'h2, 4'sh0, 5'h01, 5'h00,
                5'h00, ICT_X_READ, 4'h8);
            ICT_FLINE1: m = ict_mk(8'h19, 4'h0, -4'sh2, 5'h02, 5'h02,
                5'h04, ICT_X_NONE, 4'h0);
            ICT_FLINE2_REG: m = ict_mk(8'h1F, 4'h1, -4'sh2, 5'h02, 5'h03,
                5'h04, ICT_X_NONE, 4'h0);
            ICT_FLINE2_MEM: m = ict_mk(8'h1D, 4'h4, -4'sh2, 5'h02, 5'h02,
                5'h04, ICT_X_NONE, 4'h8);
            ICT_IRQ: m = ict_mk(8'h1E, 4'h0, -4'sh2, 5'h03, 5'h02,
                5'h04, ICT_X_NONE, 4'h4);
            ICT_FAULT_INSTR: m = ict_mk(8'h3A, 4'h0, -4'sh2, 5'h02, 5'h02,
                5'h0C, ICT_X_NONE, 4'h0);
            ICT_XRET_FAULT_INSTR: m = ict_mk(8'h32, 4'h1, -4'sh2, 5'h0C,
                5'h0C, 5'h00, ICT_X_NONE, 4'h1);
            ICT_XRET_FAULT4: m = ict_mk(8'h42, 4'h1, -4'sh2, 5'h0A, 5'h02,
                5'h04, ICT_X_NONE, 4'h0);
            ICT_XRET_FAULT6: m = ict_mk(8'h46, 4'h1, -4'sh2, 5'h0C, 5'h02,
                5'h06, ICT_X_NONE, 4'h0);
            default: m = ict_mk(8'h02, 4'h0, 4'sh0, 5'h00, 5'h01, 5'h00,
                ICT_X_NONE, 4'h0);
        endcase
        return m;
    endfunction

    // bus cycle and idle-clock counts of the operation phase
    function automatic ict_cnt_t ict_load(ict_tim_t m, logic lng,
        logic fwr, logic [7:0] credit);
        ict_cnt_t c;
        logic [7:0] tot;
        logic [7:0] bus;
        c.f = m.p + {4'h0, m.imm};
        c.r = m.r + {4'h0, lng && m.xk == ICT_X_READ};
        c.w = m.w + {4'h0, lng && m.xk == ICT_X_WRITE}
            + {4'h0, m.rerun && fwr};
        c.iack = m.iack;
        tot = m.total;
        if (lng && m.xk != ICT_X_NONE)
            tot = tot + ICT_LONG_EXTRA;
        if (m.imm)
            tot = tot + ICT_IMM_EXTRA;
        bus = {2'h0, c.f + c.r + c.w, 1'b0} + {7'h00, c.iack};
        c.i = (tot > bus) ? tot - bus : 8'h00;
        c.i = (c.i > credit) ? c.i - credit : 8'h00;
        return c;
    endfunction

endpackage

// ===== src/ict_bus_slot.sv
// instruction cycle timing: one bus cycle slot
// assumes bus_ack is synchronous; an ack in the last minimum clock
// ends the cycle, a missing ack stretches it (wait state)
`timescale 1ns/1ps
`default_nettype none

module ict_bus_slot
    import ict_pkg::*;
#(
    parameter int unsigned IACK_W = ICT_IACK_CLKS
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic start_iack,
    input wire ict_kind_t start_kind,
    input wire logic bus_ack,
    output logic busy,
    output logic done,
    output logic stall,
    output ict_kind_t bus_kind,
    output logic bus_iack
);

    if (IACK_W < 2 || IACK_W > 4) begin : g_iack_chk
        $error("ict_bus_slot: IACK_W out of range");
    end

    logic busy_q, busy_d;
    logic [1:0] cnt_q, cnt_d;
    ict_kind_t kind_q, kind_d;
    logic iack_q, iack_d;
    logic [1:0] need;

    // a plain cycle ends on its second clock, iack on its third
    assign need = iack_q ? 2'(IACK_W - 1) : 2'(ICT_BUS_CLKS - 1);
    assign done = busy_q && cnt_q == need && bus_ack;
    assign stall = busy_q && cnt_q == need && !bus_ack;
    assign busy = busy_q;
    assign bus_kind = kind_q;
    assign bus_iack = iack_q;

    always_comb begin
        busy_d = busy_q;
        cnt_d = cnt_q;
        kind_d = kind_q;
        iack_d = iack_q;
        if (start) begin
            busy_d = 1'b1;
            cnt_d = 2'h0;
            kind_d = start_kind;
            iack_d = start_iack;
        end else if (done) begin
            busy_d = 1'b0;
            iack_d = 1'b0;
        end else if (busy_q && cnt_q != need) begin
            cnt_d = cnt_q + 2'h1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            busy_q <= 1'b0;
            cnt_q <= 2'h0;
            kind_q <= ICT_READ;
            iack_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
            cnt_q <= cnt_d;
            kind_q <= kind_d;
            iack_q <= iack_d;
        end
    end

endmodule

`default_nettype wire

// ===== src/ict_engine.sv
// instruction cycle timing engine: sequences the bus cycles and idle
// clocks of one operation at a time
// assumes operations arrive from the decoder while op_ready is high
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - counts assume every operand read and write is a two-clock bus cycle.
// - reads, fetches and writes lie inside the operation's total clocks.
// - byte or word memory operand takes exactly one operand bus cycle.
// - long operand takes two bus cycles and two more clocks.
// - immediate bit-number forms spend one extra fetch beyond the count.
// - bounds check runs a three-clock one-fetch save step before address.
// - illegal coprocessor second word, memory address: save, address, op.
// - illegal coprocessor second word, register address: 31 clocks, 2/3/4.
// - illegal coprocessor first word: 25 clocks, 2/2/4.
// - interrupt takes 30 clocks with three-clock acknowledge, longer waits.
// - bus fault in an instruction ends within 58 clocks, 12 writes.
// - return from instruction fault frame reruns the write cycle that faulted.
// - return with fault on four-word frame: 66 clocks, 10/2/4.
// - return with fault on six-word frame: 70 clocks, 12/2/6.
module ict_engine
    import ict_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic op_start,
    input wire ict_op_t op_code,
    input wire logic op_long,
    input wire logic fault_was_write,
    input wire logic [7:0] ea_clks,
    input wire logic bus_ack,
    output logic op_ready,
    output logic op_done,
    output logic bus_start,
    output logic bus_active,
    output ict_kind_t bus_kind,
    output logic bus_iack,
    output logic [7:0] clk_count,
    output logic [4:0] rd_count,
    output logic [4:0] fetch_count,
    output logic [4:0] wr_count
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001, S_SAVE = 4'b0010,
        S_EA = 4'b0100, S_OPER = 4'b1000
    } ict_state_t;

    ict_state_t state_q, state_d;
    ict_op_t op_q, op_d;
    ict_tim_t tim_q, tim_d, tim_in;
    logic long_q, long_d, fwr_q, fwr_d, done_q, done_d;
    logic stall_q, stall_d;
    logic signed [3:0] ptail_q, ptail_d;
    logic [4:0] cf_q, cf_d, cr_q, cr_d, cw_q, cw_d;
    logic [7:0] ci_q, ci_d, clk_q, clk_d, exp_q, exp_d, credit;
    logic iack_q, iack_d;
    logic [4:0] nr_q, nr_d, nf_q, nf_d, nw_q, nw_d;
    logic start, start_iack, slot_busy, slot_done, slot_stall, free;
    logic finish;
    ict_kind_t start_kind;
    ict_cnt_t oc;

    assign tim_in = ict_timing(op_code);
    assign free = !slot_busy || slot_done;
    assign op_ready = state_q == S_IDLE;
    assign op_done = done_q;
    assign bus_start = start;
    assign clk_count = clk_q;
    assign rd_count = nr_q;
    assign fetch_count = nf_q;
    assign wr_count = nw_q;

    // overlap credit against the previous operation's tail
    always_comb begin
        if (ptail_q < 0)
            credit = 8'(-ptail_q);
        else if ($unsigned(ptail_q) < tim_q.head)
            credit = {4'h0, $unsigned(ptail_q)};
        else
            credit = {4'h0, tim_q.head};
    end

    assign oc = ict_load(tim_q, long_q, fwr_q, credit);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        tim_d = tim_q;
        long_d = long_q;
        fwr_d = fwr_q;
        ptail_d = ptail_q;
        cf_d = cf_q;
        cr_d = cr_q;
        cw_d = cw_q;
        ci_d = ci_q;
        iack_d = iack_q;
        clk_d = clk_q;
        exp_d = exp_q;
        stall_d = stall_q || slot_stall;
        nr_d = nr_q;
        nf_d = nf_q;
        nw_d = nw_q;
        done_d = 1'b0;
        start = 1'b0;
        start_iack = 1'b0;
        start_kind = ICT_READ;
        finish = 1'b0;
        unique case (state_q)
            S_IDLE: begin
                if (op_start) begin
                    op_d = op_code;
                    tim_d = tim_in;
                    long_d = op_long;
                    fwr_d = fault_was_write;
                    clk_d = 8'h00;
                    stall_d = 1'b0;
                    nr_d = 5'h00;
                    nf_d = 5'h00;
                    nw_d = 5'h00;
                    cr_d = 5'h00;
                    cw_d = 5'h00;
                    iack_d = 1'b0;
                    if (tim_in.save) begin
                        state_d = S_SAVE;
                        cf_d = ICT_SAVE_FETCH;
                        ci_d = ICT_SAVE_CLKS - 8'h02;
                        exp_d = ICT_SAVE_CLKS;
                    end else begin
                        state_d = S_OPER;
                        cf_d = 5'h00;
                        ci_d = 8'h00;
                        exp_d = 8'h00;
                    end
                end
            end
            S_SAVE, S_EA, S_OPER: begin
                if (free) begin
                    if (cf_q != 5'h00) begin
                        start = 1'b1;
                        start_kind = ICT_FETCH;
                        cf_d = cf_q - 5'h01;
                        nf_d = nf_q + 5'h01;
                    end else if (cr_q != 5'h00) begin
                        start = 1'b1;
                        start_iack = iack_q;
                        iack_d = 1'b0;
                        cr_d = cr_q - 5'h01;
                        nr_d = nr_q + 5'h01;
                    end else if (cw_q != 5'h00) begin
                        start = 1'b1;
                        start_kind = ICT_WRITE;
                        cw_d = cw_q - 5'h01;
                        nw_d = nw_q + 5'h01;
                    end else if (ci_q != 8'h00) begin
                        ci_d = ci_q - 8'h01;
                    end else begin
                        finish = 1'b1;
                    end
                end
                if (!finish)
                    clk_d = clk_q + 8'h01;
                if (finish && state_q == S_SAVE) begin
                    state_d = S_EA;
                    ci_d = ea_clks;
                    exp_d = exp_q + ea_clks;
                end else if (finish && state_q == S_EA) begin
                    state_d = S_OPER;
                end
                // save operations load their counts only once the address phase ends
                if (finish && state_q == S_EA) begin
                    cf_d = oc.f;
                    cr_d = oc.r;
                    cw_d = oc.w;
                    iack_d = oc.iack;
                    ci_d = oc.i;
                    exp_d = exp_q + {2'h0, oc.f + oc.r + oc.w, 1'b0}
                        + {7'h00, oc.iack} + oc.i;
                end
                if (finish && state_q == S_OPER) begin
                    state_d = S_IDLE;
                    done_d = 1'b1;
                    ptail_d = tim_q.tail;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    // non-save operations load their counts on the first busy cycle
    logic first_q, first_d;
    always_comb begin
        first_d = state_q == S_IDLE && op_start && !tim_in.save;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q <= S_IDLE;
            op_q <= ICT_BIT_REG_DN;
            tim_q <= '0;
            long_q <= 1'b0;
            fwr_q <= 1'b0;
            ptail_q <= 4'sh0;
            cf_q <= 5'h00;
            cr_q <= 5'h00;
            cw_q <= 5'h00;
            ci_q <= 8'h00;
            iack_q <= 1'b0;
            clk_q <= 8'h00;
            exp_q <= 8'h00;
            stall_q <= 1'b0;
            nr_q <= 5'h00;
            nf_q <= 5'h00;
            nw_q <= 5'h00;
            done_q <= 1'b0;
            first_q <= 1'b0;
        end else if (first_q) begin
            cf_q <= oc.f;
            cr_q <= oc.r;
            cw_q <= oc.w;
            ci_q <= oc.i - 8'(oc.i != 8'h00);
            iack_q <= oc.iack;
            exp_q <= {2'h0, oc.f + oc.r + oc.w, 1'b0} + {7'h00, oc.iack}
                + oc.i;
            first_q <= 1'b0;
            // load clock hides in an idle clock; with none it is overhead
            clk_q <= {7'h00, oc.i != 8'h00};
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            tim_q <= tim_d;
            long_q <= long_d;
            fwr_q <= fwr_d;
            ptail_q <= ptail_d;
            cf_q <= cf_d;
            cr_q <= cr_d;
            cw_q <= cw_d;
            ci_q <= ci_d;
            iack_q <= iack_d;
            clk_q <= clk_d;
            exp_q <= exp_d;
            stall_q <= stall_d;
            nr_q <= nr_d;
            nf_q <= nf_d;
            nw_q <= nw_d;
            done_q <= done_d;
            first_q <= first_d;
        end
    end

    ict_bus_slot u_slot (
        .core_clk(core_clk),
        .reset(reset),
        .start(start),
        .start_iack(start_iack),
        .start_kind(start_kind),
        .bus_ack(bus_ack),
        .busy(slot_busy),
        .done(slot_done),
        .stall(slot_stall),
        .bus_kind(bus_kind),
        .bus_iack(bus_iack)
    );
    assign bus_active = slot_busy;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_two_clk;
        @(posedge core_clk) disable iff (reset)
        (start && !start_iack) |=> !slot_stall ##1 (!bus_ack || slot_done);
    endproperty
    a_two_clk: assert property (p_two_clk)
        else $error("plain bus cycle not ended on its second clock");

    property p_total;
        @(posedge core_clk) disable iff (reset)
        (done_q && !stall_q) |-> clk_q == exp_q;
    endproperty
    a_total: assert property (p_total)
        else $error("operation clocks differ from expected total");

    property p_short_op;
        @(posedge core_clk) disable iff (reset)
        (done_q && op_q == ICT_PBC && !long_q) |-> nr_q == 5'h01;
    endproperty
    a_short_op: assert property (p_short_op)
        else $error("short operand not one bus cycle");

    property p_long_op;
        @(posedge core_clk) disable iff (reset)
        (done_q && op_q == ICT_BIT_REG_MEM && long_q) |-> nw_q == 5'h02;
    endproperty
    a_long_op: assert property (p_long_op)
        else $error("long operand not two bus cycles");

    property p_imm_fetch;
        @(posedge core_clk) disable iff (reset)
        (done_q && op_q == ICT_BIT_IMM_DN) |-> nf_q == 5'h03;
    endproperty
    a_imm_fetch: assert property (p_imm_fetch)
        else $error("immediate bit number fetch missing");

    property p_save_fetch;
        @(posedge core_clk) disable iff (reset)
        (state_q == S_SAVE && $past(state_q) == S_IDLE) |->
            start && start_kind == ICT_FETCH;
    endproperty
    a_save_fetch: assert property (p_save_fetch)
        else $error("save step does not open with a fetch");

    property p_iack;
        @(posedge core_clk) disable iff (reset)
        start_iack |=> !slot_stall ##1 !slot_stall ##1
            (!bus_ack || slot_done);
    endproperty
    a_iack: assert property (p_iack)
        else $error("acknowledge cycle not three clocks");

    property p_fault_max;
        @(posedge core_clk) disable iff (reset)
        (done_q && op_q == ICT_FAULT_INSTR && !stall_q) |->
            clk_q <= ICT_FAULT_MAX && nw_q == 5'h0C;
    endproperty
    a_fault_max: assert property (p_fault_max)
        else $error("bus fault processing too long");

    property p_rerun;
        @(posedge core_clk) disable iff (reset)
        (done_q && op_q == ICT_XRET_FAULT_INSTR) |-> nw_q == {4'h0, fwr_q};
    endproperty
    a_rerun: assert property (p_rerun)
        else $error("faulted write not rerun");

    property p_loop;
        @(posedge core_clk) disable iff (reset)
        (state_q != S_IDLE && op_q == ICT_DBR_LOOP) |->
            !(start && start_kind == ICT_FETCH);
    endproperty
    a_loop: assert property (p_loop)
        else $error("loop mode fetched");

    c_irq: cover property (@(posedge core_clk) done_q && op_q == ICT_IRQ);
    c_save: cover property (@(posedge core_clk)
        done_q && op_q == ICT_FLINE2_MEM);
    c_rerun: cover property (@(posedge core_clk)
        done_q && op_q == ICT_XRET_FAULT_INSTR && fwr_q);

endmodule

`default_nettype wire

// ===== tb/ict_mem_model.sv
// instruction cycle timing: memory and peripheral side of the bus
// assumes bus_active stays high until bus_ack is seen at an edge
`timescale 1ns/1ps
`default_nettype none

module ict_mem_model
    import ict_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic bus_active,
    input wire logic bus_iack,
    input wire logic [3:0] wait_clks,
    output logic bus_ack
);
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic [4:0] need;
    // acknowledge runs three clocks minimum; waits stretch any cycle
    assign need = (bus_iack ? 5'h03 : 5'h02) + {1'b0, wait_clks};
    assign bus_ack = bus_active && (cnt_q + 5'h01 >= need);
    always_comb begin
        cnt_d = cnt_q + 5'h01;
        if (!bus_active || bus_ack) begin
            cnt_d = 5'h00;
        end
    end
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// ===== tb/test_cpu_instruction_cycle_timing.sv
// instruction cycle timing: self-checking bench for the engine
// assumes reset before each operation unless tail credit is under test
`timescale 1ns/1ps
`default_nettype none

module test_cpu_instruction_cycle_timing;
    import ict_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic op_start = 1'b0;
    ict_op_t op_code = ICT_BIT_IMM_DN;
    logic op_long = 1'b0;
    logic fault_was_write = 1'b0;
    logic [7:0] ea_clks = 8'h00;
    logic [3:0] wait_clks = 4'h0;
    logic bus_ack;
    logic op_ready;
    logic op_done;
    logic [7:0] clk_count;
    logic [4:0] rd_count;
    logic [4:0] fetch_count;
    logic [4:0] wr_count;
    logic bus_active;
    logic bus_iack;
    int bad_count = 0;
    int check_count = 0;

    always #10 core_clk = ~core_clk;

    ict_engine ict_engine_inst (.core_clk(core_clk), .reset(reset),
        .op_start(op_start), .op_code(op_code), .op_long(op_long),
        .fault_was_write(fault_was_write), .ea_clks(ea_clks),
        .bus_ack(bus_ack), .op_ready(op_ready), .op_done(op_done),
        .bus_start(), .bus_active(bus_active), .bus_kind(),
        .bus_iack(bus_iack), .clk_count(clk_count), .rd_count(rd_count),
        .fetch_count(fetch_count), .wr_count(wr_count));
    ict_mem_model ict_mem_model_inst (.core_clk(core_clk), .reset(reset),
        .bus_active(bus_active), .bus_iack(bus_iack),
        .wait_clks(wait_clks), .bus_ack(bus_ack));

    task automatic check(input string nm, input logic [7:0] seen,
        input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %0d seen %0d", nm, exp, seen);
        end
    endtask

    task automatic run_op(input ict_op_t op, input logic lng,
        input logic fw, input logic [7:0] ea, input logic [3:0] wt);
        int n;
        @(negedge core_clk);
        reset = 1'b1;
        op_code = op;
        op_long = lng;
        fault_was_write = fw;
        ea_clks = ea;
        wait_clks = wt;
        @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);
        op_start = 1'b1;
        @(negedge core_clk);
        op_start = 1'b0;
        n = 0;
        while (op_done !== 1'b1 && n < 600) begin
            @(negedge core_clk);
            n++;
        end
        check("op_done", {7'h00, op_done}, 8'h01);
    endtask

    task automatic counts(input logic [7:0] c, input logic [4:0] r,
        input logic [4:0] p, input logic [4:0] w);
        check("clk_count", clk_count, c);
        check("rd_count", {3'h0, rd_count}, {3'h0, r});
        check("fetch_count", {3'h0, fetch_count}, {3'h0, p});
        check("wr_count", {3'h0, wr_count}, {3'h0, w});
    endtask

    task automatic t_bits();
        run_op(ICT_BIT_REG_MEM, 1'b0, 1'b0, 8'h00, 4'h0);
        counts(8'h08, 5'h00, 5'h01, 5'h01);
        run_op(ICT_BIT_REG_MEM, 1'b1, 1'b0, 8'h00, 4'h0);
        counts(8'h0a, 5'h00, 5'h01, 5'h02);
        run_op(ICT_BIT_IMM_DN, 1'b0, 1'b0, 8'h00, 4'h0);
        counts(8'h08, 5'h00, 5'h03, 5'h00);
        run_op(ICT_DBR_LOOP, 1'b0, 1'b0, 8'h00, 4'h0);
        counts(8'h0a, 5'h00, 5'h00, 5'h00);
        $display("test bits and loop done");
    endtask

    task automatic t_save();
        run_op(ICT_PBC, 1'b1, 1'b0, 8'h04, 4'h0);
        check("pbc_reads", {3'h0, rd_count}, 8'h02);
        check("pbc_fetch", {3'h0, fetch_count}, 8'h01);
        check("pbc_clks", {7'h00, clk_count >= 8'h1b}, 8'h01);
        run_op(ICT_PBC, 1'b0, 1'b0, 8'h00, 4'h0);
        check("pbc_short_rd", {3'h0, rd_count}, 8'h01);
        check("pbc_short_clk", clk_count, 8'h15);
        run_op(ICT_FLINE2_MEM, 1'b0, 1'b0, 8'h04, 4'h0);
        check("fl2_fetch", {3'h0, fetch_count}, 8'h03);
        check("fl2_clks", {7'h00, clk_count >= 8'h24}, 8'h01);
        run_op(ICT_FLINE2_REG, 1'b0, 1'b0, 8'h00, 4'h0);
        counts(8'h1f, 5'h02, 5'h03, 5'h04);
        run_op(ICT_FLINE1, 1'b0, 1'b0, 8'h00, 4'h0);
        counts(8'h19, 5'h02, 5'h02, 5'h04);
        $display("test save steps done");
    endtask

    task automatic t_exc();
        run_op(ICT_IRQ, 1'b0, 1'b0, 8'h00, 4'h0);
        counts(8'h1e, 5'h03, 5'h02, 5'h04);
        run_op(ICT_IRQ, 1'b0, 1'b0, 8'h00, 4'h1);
        check("irq_wait", {7'h00, clk_count > 8'h1e}, 8'h01);
        run_op(ICT_FAULT_INSTR, 1'b0, 1'b0, 8'h00, 4'h0);
        check("fault_max", {7'h00, clk_count <= 8'h3a}, 8'h01);
        check("fault_wr", {3'h0, wr_count}, 8'h0c);
        run_op(ICT_XRET_FAULT_INSTR, 1'b0, 1'b1, 8'h00, 4'h0);
        check("rerun_wr", {3'h0, wr_count}, 8'h01);
        check("rerun_clk", clk_count, 8'h32);
        run_op(ICT_XRET_FAULT_INSTR, 1'b0, 1'b0, 8'h00, 4'h0);
        check("no_rerun_wr", {3'h0, wr_count}, 8'h00);
        run_op(ICT_XRET_FAULT4, 1'b0, 1'b0, 8'h00, 4'h0);
        counts(8'h42, 5'h0a, 5'h02, 5'h04);
        run_op(ICT_XRET_FAULT6, 1'b0, 1'b0, 8'h00, 4'h0);
        counts(8'h46, 5'h0c, 5'h02, 5'h06);
        $display("test exceptions done");
    endtask

    // second operation follows without reset to use the tail credit
    task automatic t_overlap();
        int n;
        run_op(ICT_FLINE1, 1'b0, 1'b0, 8'h00, 4'h0);
        op_code = ICT_DBR_LOOP;
        op_start = 1'b1;
        @(negedge core_clk);
        op_start = 1'b0;
        n = 0;
        while (op_done !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        check("ovl_done", {7'h00, op_done}, 8'h01);
        counts(8'h08, 5'h00, 5'h00, 5'h00);
        $display("test tail overlap done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(negedge core_clk);
        reset = 1'b0;
        t_bits();
        t_save();
        t_exc();
        t_overlap();
        stop_test();
    end

    // about 20 operations of under 200 clocks each
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire
